//--- rtl/cpu_ctl_pkg.sv
// Purpose: shared types and constants for the core address and state control block
// Assumes: 24-bit address space, 125 MHz ref_clk
// Notes:   modes and states are enums, request groups travel as packed structs
package cpu_ctl_pkg;

    // ------------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------------
    localparam int ADDR_W          = 24;
    localparam logic [15:0] ABS8_UPPER      = 16'hffff; // upper bits for 8-bit data address
    localparam logic [7:0]  MEMIND_TOP_BYTE = 8'h00;    // first byte of indirect longword
    localparam logic [15:0] MEMIND_BASE     = 16'h0000; // upper bits of indirect pointer

    typedef enum logic [2:0] {
        EA_ABS8    = 3'b000,
        EA_ABS16   = 3'b001,
        EA_ABS24   = 3'b010,
        EA_ABS32   = 3'b011,
        EA_PCREL8  = 3'b100,
        EA_PCREL16 = 3'b101,
        EA_MEMIND  = 3'b110,
        EA_IMM     = 3'b111
    } ea_mode_type;

    typedef struct packed {
        logic        valid;
        ea_mode_type mode;
        logic [31:0] ext;     // extension word from the instruction
        logic [23:0] pc;      // address of the next instruction
        logic [31:0] mem_rd;  // longword fetched for memory indirect
    } ea_req_type;

    typedef struct packed {
        logic        valid;
        logic        is_imm;
        logic        need_mem;  // memory indirect pointer address in addr
        logic [23:0] addr;
    } ea_rsp_type;

    // ------------------------------------------------------------------
    // processing states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_EXC    = 3'b001,
        ST_VECRD  = 3'b010,
        ST_EXEC   = 3'b011,
        ST_STOP   = 3'b100
    } proc_state_type;

    // exception sources other than reset
    typedef struct packed {
        logic trace;
        logic irq;
        logic trap;
    } exc_src_type;

    // ------------------------------------------------------------------
    // instruction checks
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BIT_SET    = 3'b000,
        BIT_CLEAR  = 3'b001,
        BIT_INVERT = 3'b010,
        BIT_STORE  = 3'b011,
        BIT_STINV  = 3'b100
    } bit_op_type;

    localparam logic [2:0] SP_REG_IDX = 3'd7;  // stack pointer extended register
    localparam logic [15:0] MOVE_ADDR_LIMIT = 16'hffff;

endpackage

//--- rtl/cpu_state_ctl.sv
// Purpose: processing state sequencing, address formation and instruction checks
// Assumes: instruction decode supplies one-cycle strobes synchronous to ref_clk
// Notes:   reset sources are pin, watchdog overflow and low-voltage detect
//
// Operation
// - pin reset low abandons all work and enters reset state at once
// - in reset, core and peripherals are held initialized and stopped
// - every interrupt source is masked while in reset
// - reset exception handling starts once the pin is high and no internal source is active
// - watchdog overflow or low-voltage detect also forces reset
// - reset, trace, interrupt or trap enters exception handling
// - exception handling reads a vector then branches to it
// - program execution fetches and executes instructions in sequence
// - sleep instruction or software standby enters program stop
// - memory indirect supports only the 24-bit advanced form
// - bit set/clear/invert/store/store-inverted read byte, modify, write byte
// - block move copies count bytes from source pointer to destination
// - multi-register push/pop refuses the stack pointer register
// - push/pop groups only 0-1, 2-3, 4-5, 0-2, 4-6, 0-3
// - 8-bit data address fills upper bits with ones
// - 16-bit data address sign-extends into upper bits
// - pc-relative adds sign-extended displacement to 24-bit pc
// - memory indirect reads longword branch address, top byte zero
`timescale 1ns/10ps
module cpu_state_ctl (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    // reset sources
    input  wire logic                          external_reset_pin_n,
    input  wire logic                          wdt_overflow,
    input  wire logic                          lvd_detect,
    // exception and power-down requests
    input  wire cpu_ctl_pkg::exc_src_type       exc_req,
    input  wire logic                          sleep_exec,
    input  wire logic                          sw_standby,
    // vector read from memory
    input  wire logic                          vec_valid,
    input  wire logic [23:0]                   vec_data,
    // address formation
    input  wire cpu_ctl_pkg::ea_req_type        ea_req,
    output cpu_ctl_pkg::ea_rsp_type             ea_rsp,
    // bit operation read-modify-write
    input  wire logic                          bit_op_valid,
    input  wire cpu_ctl_pkg::bit_op_type        bit_op,
    input  wire logic [2:0]                    bit_num,
    input  wire logic                          bit_src,
    input  wire logic [7:0]                    bit_rd_byte,
    output logic [7:0]                         bit_wr_byte,
    output logic                               bit_wr_valid,
    // block move
    input  wire logic                          move_start,
    input  wire logic [7:0]                    move_count_byte_reg,
    input  wire logic [15:0]                   move_source_pointer_reg,
    input  wire logic [15:0]                   move_dest_pointer_reg,
    input  wire logic                          move_ack,
    output logic                               move_busy,
    output logic [15:0]                        move_rd_addr,
    output logic [15:0]                        move_wr_addr,
    // multi-register stack transfer check
    input  wire logic                          mreg_valid,
    input  wire logic [2:0]                    mreg_first,
    input  wire logic [1:0]                    mreg_extra,
    output logic                               mreg_illegal,
    // state outputs
    output cpu_ctl_pkg::proc_state_type         proc_state,
    output logic                               periph_reset_n,
    output logic                               irq_mask,
    output logic                               fetch_en,
    output logic                               pc_load,
    output logic [23:0]                        pc_load_addr,
    output logic                               vec_rd_req
);
    import cpu_ctl_pkg::*;

    // --------------------------------------------------------------
    // reset synchroniser
    // --------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // --------------------------------------------------------------
    // reset request and pin edge
    // --------------------------------------------------------------
    logic pin_q;
    logic reset_req;
    logic pin_rise;
    // internal sources and pin low all hold the core in reset
    assign reset_req = !external_reset_pin_n || wdt_overflow || lvd_detect;
    assign pin_rise  = external_reset_pin_n && !pin_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 1'b1; // idle level, no false edge
        end else begin
            pin_q <= external_reset_pin_n;
        end
    end

    // --------------------------------------------------------------
    // processing state machine
    // --------------------------------------------------------------
    proc_state_type st_d, st_q;
    logic [23:0]    pcl_addr_d, pcl_addr_q;
    logic           pcl_d, pcl_q;
    logic           src_reset_d, src_reset_q;

    always_comb begin
        st_d        = st_q;
        pcl_d       = 1'b0;
        pcl_addr_d  = pcl_addr_q;
        src_reset_d = src_reset_q;
        if (reset_req) begin
            st_d        = ST_RESET;
            src_reset_d = 1'b1;
        end else begin
            case (st_q)
                ST_RESET: begin
                    // internal sources release without a pin edge
                    if (pin_rise || external_reset_pin_n) begin
                        st_d = ST_EXC;
                    end
                end
                ST_EXC: begin
                    st_d = ST_VECRD;
                end
                ST_VECRD: begin
                    if (vec_valid) begin
                        pcl_d       = 1'b1;
                        pcl_addr_d  = vec_data;
                        src_reset_d = 1'b0;
                        st_d        = ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (exc_req.trace || exc_req.irq || exc_req.trap) begin
                        st_d = ST_EXC;
                    end else if (sleep_exec || sw_standby) begin
                        st_d = ST_STOP;
                    end
                end
                ST_STOP: begin
                    // a pending interrupt wakes the core through exception handling while sw_standby is low
                    if (exc_req.irq && !sw_standby) begin
                        st_d = ST_EXC;
                    end
                end
                default: begin
                    st_d = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= ST_RESET;
            pcl_q       <= 1'b0;
            pcl_addr_q  <= '0;
            src_reset_q <= 1'b1;
        end else begin
            st_q        <= st_d;
            pcl_q       <= pcl_d;
            pcl_addr_q  <= pcl_addr_d;
            src_reset_q <= src_reset_d;
        end
    end

    // state outputs
    assign proc_state     = st_q;
    assign periph_reset_n = (st_q != ST_RESET);
    assign irq_mask       = (st_q == ST_RESET) || src_reset_q;
    assign fetch_en       = (st_q == ST_EXEC);
    assign vec_rd_req     = (st_q == ST_VECRD);
    assign pc_load        = pcl_q;
    assign pc_load_addr   = pcl_addr_q;

    // --------------------------------------------------------------
    // address formation unit
    // --------------------------------------------------------------
    ea_req_type ea_req_gated;
    always_comb begin
        ea_req_gated = ea_req;
        if (ea_req.mode == EA_MEMIND) begin
            ea_req_gated.mem_rd = {MEMIND_TOP_BYTE, ea_req.mem_rd[23:0]};
        end
    end

    ea_calc u_ea (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .req   (ea_req_gated),
        .rsp   (ea_rsp)
    );

    // --------------------------------------------------------------
    // bit operation: whole byte in, whole byte out
    // --------------------------------------------------------------
    logic [7:0] bit_byte_d, bit_byte_q;
    logic       bit_v_d, bit_v_q;
    always_comb begin
        bit_byte_d = bit_rd_byte;
        bit_v_d    = bit_op_valid && fetch_en;
        case (bit_op)
            BIT_SET:    bit_byte_d[bit_num] = 1'b1;
            BIT_CLEAR:  bit_byte_d[bit_num] = 1'b0;
            BIT_INVERT: bit_byte_d[bit_num] = ~bit_rd_byte[bit_num];
            BIT_STORE:  bit_byte_d[bit_num] = bit_src;
            BIT_STINV:  bit_byte_d[bit_num] = ~bit_src;
            default:    bit_byte_d          = bit_rd_byte;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_byte_q <= '0;
            bit_v_q    <= 1'b0;
        end else begin
            bit_byte_q <= bit_byte_d;
            bit_v_q    <= bit_v_d;
        end
    end
    assign bit_wr_byte  = bit_byte_q;
    assign bit_wr_valid = bit_v_q;

    // --------------------------------------------------------------
    // block move sequencer
    // --------------------------------------------------------------
    logic [7:0]  mv_cnt_d, mv_cnt_q;
    logic [15:0] mv_src_d, mv_src_q;
    logic [15:0] mv_dst_d, mv_dst_q;
    logic        mv_busy_d, mv_busy_q;
    always_comb begin
        mv_cnt_d  = mv_cnt_q;
        mv_src_d  = mv_src_q;
        mv_dst_d  = mv_dst_q;
        mv_busy_d = mv_busy_q;
        if (!fetch_en) begin
            mv_busy_d = 1'b0;
        end else if (!mv_busy_q && move_start && move_count_byte_reg != 8'h00) begin
            mv_cnt_d  = move_count_byte_reg;
            mv_src_d  = move_source_pointer_reg;
            mv_dst_d  = move_dest_pointer_reg;
            mv_busy_d = 1'b1;
        end else if (mv_busy_q && move_ack) begin
            mv_cnt_d  = mv_cnt_q - 8'h01;
            mv_src_d  = mv_src_q + 16'h0001;
            // no wrap guard: software keeps the range in bounds
            mv_dst_d  = mv_dst_q + 16'h0001;
            mv_busy_d = (mv_cnt_q != 8'h01);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mv_cnt_q  <= '0;
            mv_src_q  <= '0;
            mv_dst_q  <= '0;
            mv_busy_q <= 1'b0;
        end else begin
            mv_cnt_q  <= mv_cnt_d;
            mv_src_q  <= mv_src_d;
            mv_dst_q  <= mv_dst_d;
            mv_busy_q <= mv_busy_d;
        end
    end
    assign move_busy    = mv_busy_q;
    assign move_rd_addr = mv_src_q;
    assign move_wr_addr = mv_dst_q;

    // --------------------------------------------------------------
    // multi-register push/pop legality
    // --------------------------------------------------------------
    logic       grp_ok;
    logic [2:0] mreg_last;
    always_comb begin
        mreg_last = mreg_first + {1'b0, mreg_extra};
        case ({mreg_first, mreg_extra})
            {3'd0, 2'd1}, {3'd2, 2'd1}, {3'd4, 2'd1}: grp_ok = 1'b1;
            {3'd0, 2'd2}, {3'd4, 2'd2}:               grp_ok = 1'b1;
            {3'd0, 2'd3}:                             grp_ok = 1'b1;
            default:                                  grp_ok = 1'b0;
        endcase
        if (mreg_last == SP_REG_IDX) begin
            grp_ok = 1'b0;
        end
    end
    assign mreg_illegal = mreg_valid && !grp_ok;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_reset_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !external_reset_pin_n |=> proc_state == ST_RESET)
        else $error("pin reset did not enter reset state");
    a_wdt_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wdt_overflow || lvd_detect) |=> proc_state == ST_RESET && !periph_reset_n)
        else $error("internal reset source ignored");
    a_reset_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
        proc_state == ST_RESET |-> irq_mask && !fetch_en)
        else $error("interrupts unmasked in reset");
    a_release_exc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rst_n && proc_state == ST_RESET && !reset_req ##1 !reset_req |-> proc_state == ST_EXC)
        else $error("no exception handling after reset release");
    a_vector_branch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        proc_state == ST_VECRD && vec_valid && !reset_req
        |=> pc_load && pc_load_addr == $past(vec_data) && proc_state == ST_EXEC)
        else $error("vector branch missing");
    a_sleep_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        proc_state == ST_EXEC && sleep_exec && !reset_req && !(|exc_req)
        |=> proc_state == ST_STOP && !fetch_en)
        else $error("sleep did not stop core");
    a_bit_rmw: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bit_op_valid && fetch_en && bit_op == BIT_CLEAR
        |=> bit_wr_valid && bit_wr_byte == ($past(bit_rd_byte) & ~(8'h01 << $past(bit_num))))
        else $error("bit clear byte wrong");
    a_move_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fetch_en && !move_busy && move_start && move_count_byte_reg == 8'h01 && !reset_req
        ##1 move_ack |=> !move_busy)
        else $error("single byte move did not finish");
    a_sp_refused: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mreg_valid && mreg_first + {1'b0, mreg_extra} == 3'd7 |-> mreg_illegal)
        else $error("stack pointer accepted in push/pop");
    c_reset_to_exec: cover property (@(posedge ref_clk) disable iff (!rst_n)
        proc_state == ST_VECRD ##1 proc_state == ST_EXEC);
    c_stop: cover property (@(posedge ref_clk) disable iff (!rst_n)
        proc_state == ST_STOP ##1 proc_state == ST_RESET);
    c_move: cover property (@(posedge ref_clk) disable iff (!rst_n)
        move_busy ##1 !move_busy);
endmodule

//--- rtl/ea_calc.sv
// Purpose: effective address formation for absolute, immediate, pc-relative, indirect
// Assumes: one request per cycle, memory longword presented with the second request
// Notes:   registered result, one cycle latency
`timescale 1ns/10ps
module ea_calc (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // request and answer
    input  wire cpu_ctl_pkg::ea_req_type req,
    output cpu_ctl_pkg::ea_rsp_type      rsp
);
    import cpu_ctl_pkg::*;

    ea_rsp_type rsp_d;
    ea_rsp_type rsp_q;
    logic [23:0] disp_ext;

    // --------------------------------------------------------------
    // combinational address formation
    // --------------------------------------------------------------
    always_comb begin
        rsp_d          = '0;
        rsp_d.valid    = req.valid;
        disp_ext       = '0;
        case (req.mode)
            EA_ABS8: begin
                rsp_d.addr = {ABS8_UPPER, req.ext[7:0]};
            end
            EA_ABS16: begin
                rsp_d.addr = {{8{req.ext[15]}}, req.ext[15:0]};
            end
            EA_ABS24, EA_ABS32: begin
                rsp_d.addr = req.ext[23:0];  // upper byte is don't care
            end
            EA_PCREL8: begin
                disp_ext   = {{16{req.ext[7]}}, req.ext[7:0]};
                rsp_d.addr = req.pc + disp_ext;
            end
            EA_PCREL16: begin
                disp_ext   = {{8{req.ext[15]}}, req.ext[15:0]};
                rsp_d.addr = req.pc + disp_ext;
            end
            EA_MEMIND: begin
                // only the 24-bit advanced form exists; no 16-bit normal variant
                rsp_d.need_mem = 1'b1;
                rsp_d.addr     = {MEMIND_BASE, req.ext[7:0]};
            end
            EA_IMM: begin
                rsp_d.is_imm = 1'b1;
            end
            default: begin
                rsp_d.addr = '0;
            end
        endcase
    end

    // result register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp = rsp_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_abs8_ones: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && req.mode == EA_ABS8 |=> rsp.addr[23:8] == 16'hffff)
        else $error("8-bit absolute address upper bits not ones");
    a_abs16_sign: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && req.mode == EA_ABS16 |=> rsp.addr[23:16] == {8{$past(req.ext[15])}})
        else $error("16-bit absolute address not sign extended");
    a_pcrel_sum: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && req.mode == EA_PCREL8
        |=> rsp.addr == 24'($past(req.pc) + {{16{$past(req.ext[7])}}, $past(req.ext[7:0])}))
        else $error("pc relative target wrong");
    c_memind: cover property (@(posedge clk) disable iff (!rst_n)
        req.valid && req.mode == EA_MEMIND);
endmodule

//--- tb/mem_periph_model.sv
// Purpose: memory and peripheral side: vector reads and block-move byte copies
// Assumes: design samples at the rising edge, so answers move at the falling edge
// Notes:   slow mode acks every other cycle, stalling the move
`timescale 1ns/10ps
module mem_periph_model #(
    parameter logic [23:0] VEC = 24'h000400
) (
    // clock
    input  wire logic        ref_clk,
    // vector read
    input  wire logic        vec_rd_req,
    output logic             vec_valid,
    output logic [23:0]      vec_data,
    // block move
    input  wire logic        slow,
    input  wire logic        move_busy,
    input  wire logic [15:0] move_rd_addr,
    input  wire logic [15:0] move_wr_addr,
    output logic             move_ack
);
    logic [7:0] mem [0:65535];
    logic       tog = 1'b0;
    // distinct byte per location within each 256-byte block so a wrong source shows
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
        vec_valid = 1'b0;
        move_ack  = 1'b0;
    end
    // one byte copied per ack, at the addresses the design shows
    always @(negedge ref_clk) begin
        tog       <= ~tog;
        vec_valid <= vec_rd_req;
        move_ack  <= move_busy && (!slow || tog);
        if (move_busy && (!slow || tog)) begin
            mem[move_wr_addr] <= mem[move_rd_addr];
        end
    end
    // no stale vector outside a valid cycle
    assign vec_data = vec_valid ? VEC : ~VEC;
endmodule

//--- tb/tb_cpu_state_ctl.sv
// Purpose: scenario bench for state sequencing, address formation and checks
// Assumes: inputs driven at the falling edge
// Notes:   stop entered by sleep, then by software standby
`timescale 1ns/10ps
module tb_cpu_state_ctl;
    import cpu_ctl_pkg::*;
    localparam logic [23:0] VEC = 24'h000400;
    logic ref_clk = 0, resetn = 0, external_reset_pin_n = 1, wdt_overflow = 0;
    logic lvd_detect = 0, sleep_exec = 0, sw_standby = 0, vec_valid, vec_rd_req;
    logic bit_op_valid = 0, bit_src = 0, move_start = 0, move_ack, slow = 0;
    logic mreg_valid = 0, mreg_illegal, bit_wr_valid, move_busy, periph_reset_n;
    logic irq_mask, fetch_en, pc_load;
    logic [2:0] bit_num = 0, mreg_first = 0;
    logic [1:0] mreg_extra = 0;
    logic [7:0] bit_rd_byte = 0, bit_wr_byte, move_count_byte_reg = 0;
    logic [15:0] move_source_pointer_reg = 0, move_dest_pointer_reg = 0;
    logic [15:0] move_rd_addr, move_wr_addr;
    logic [23:0] vec_data, pc_load_addr;
    exc_src_type exc_req = '0;
    ea_req_type ea_req = '0;
    ea_rsp_type ea_rsp;
    bit_op_type bit_op = BIT_SET;
    proc_state_type proc_state;
    int failures = 0, cmp_count = 0, cycles = 0;

    cpu_state_ctl DUT (.ref_clk, .resetn, .external_reset_pin_n, .wdt_overflow,
        .lvd_detect, .exc_req, .sleep_exec, .sw_standby, .vec_valid, .vec_data, .ea_req,
        .ea_rsp, .bit_op_valid, .bit_op, .bit_num, .bit_src, .bit_rd_byte, .bit_wr_byte,
        .bit_wr_valid, .move_start, .move_count_byte_reg, .move_source_pointer_reg,
        .move_dest_pointer_reg, .move_ack, .move_busy, .move_rd_addr, .move_wr_addr,
        .mreg_valid, .mreg_first, .mreg_extra, .mreg_illegal, .proc_state,
        .periph_reset_n, .irq_mask, .fetch_en, .pc_load, .pc_load_addr, .vec_rd_req);
    mem_periph_model #(.VEC(VEC)) MEM (.ref_clk, .vec_rd_req, .vec_valid, .vec_data,
        .slow, .move_busy, .move_rd_addr, .move_wr_addr, .move_ack);

    // ----------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ----------------------------------------------------------------
    always #4 ref_clk = ~ref_clk;
    // run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            failures++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // bounded wait for execution, then the vector branch must be seen
    task automatic wait_exec();
        for (int k = 0; k < 20 && proc_state !== ST_EXEC; k++) cyc(1);
        chk(pc_load === 1 && pc_load_addr === VEC && fetch_en === 1, "vector branch");
    endtask
    // src 0 pin, 1 watchdog, 2 low voltage; optionally from stop
    task automatic reset_from(input int src, input logic stop_first);
        if (stop_first) begin
            {sleep_exec, sw_standby} = {src == 1, src != 1};
            cyc(1);
            {sleep_exec, sw_standby} = 2'b00;
            chk(proc_state === ST_STOP && fetch_en === 0, "no stop");
        end
        external_reset_pin_n = (src != 0);
        wdt_overflow = (src == 1);
        lvd_detect = (src == 2);
        cyc(2);
        chk(proc_state === ST_RESET && periph_reset_n === 0 && irq_mask === 1, "rst");
        {external_reset_pin_n, wdt_overflow, lvd_detect} = 3'b100;
        cyc(1);
        chk(proc_state === ST_EXC, "no reset exception");
        wait_exec();
    endtask
    task automatic ea_chk(input ea_mode_type m, input logic [31:0] x, input logic [23:0] e);
        ea_req = '{valid: 1, mode: m, ext: x, pc: 24'hfffff0, mem_rd: 32'hffabcdef};
        cyc(1);
        chk(ea_rsp.valid === 1 && ea_rsp.addr === e, "address");
        chk(ea_rsp.need_mem === (m == EA_MEMIND) && ea_rsp.is_imm === (m == EA_IMM),
            "mode flag");
    endtask
    task automatic bit_chk(input bit_op_type o, input int n, input logic [7:0] r, e);
        bit_op = o;
        {bit_op_valid, bit_num, bit_src, bit_rd_byte} = {1'b1, 3'(n), 1'b1, r};
        cyc(1);
        chk(bit_wr_valid === 1 && bit_wr_byte === e, "bit byte");
    endtask
    // destination ends one byte below the top of the 16-bit range, never wrapping
    task automatic move_chk(input logic [7:0] n, input logic s);
        {slow, move_count_byte_reg, move_source_pointer_reg} = {s, n, 16'h1000};
        move_dest_pointer_reg = 16'hffff - 16'(n);
        move_start = 1;
        cyc(1);
        move_start = 0;
        chk(move_busy === (n != 0), "move start");
        for (int k = 0; k < 40 && move_busy !== 0; k++) cyc(1);
        for (int i = 0; i <= n; i++) begin
            chk(MEM.mem[16'hffff - n + i] === ((i == n) ? 8'ha5 : 8'(i) ^ 8'h5a), "copy");
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(3);
        resetn = 1;
        wait_exec();
        ea_chk(EA_ABS8, 32'h12, 24'hffff12);
        ea_chk(EA_ABS16, 32'h8000, 24'hff8000);
        ea_chk(EA_ABS16, 32'h7fff, 24'h007fff);
        ea_chk(EA_PCREL8, 32'hfe, 24'hffffee);
        ea_chk(EA_PCREL16, 32'h0100, 24'h0000f0);
        ea_chk(EA_MEMIND, 32'h40, 24'h000040);
        ea_chk(EA_ABS32, 32'hff123456, 24'h123456);
        ea_chk(EA_IMM, 32'h55, 24'h000000);
        ea_req.valid = 0;
        bit_chk(BIT_SET, 3, 8'h00, 8'h08);
        bit_chk(BIT_CLEAR, 0, 8'hff, 8'hfe);
        bit_chk(BIT_INVERT, 7, 8'h0f, 8'h8f);
        bit_chk(BIT_STORE, 2, 8'h00, 8'h04);
        bit_chk(BIT_STINV, 2, 8'hff, 8'hfb);
        bit_op_valid = 0;
        mreg_valid = 1;
        for (int f = 0; f < 8; f++) for (int x = 0; x < 4; x++) begin
            {mreg_first, mreg_extra} = {3'(f), 2'(x)};
            cyc(1);
            chk(mreg_illegal === !((x == 1 && f inside {0, 2, 4}) || (x == 2 && f inside {0, 4})
                || (x == 3 && f == 0)), "group");
        end
        move_chk(8'd0, 0);
        move_chk(8'd3, 1);
        move_chk(8'd1, 0);
        for (int i = 0; i < 3; i++) begin
            exc_req = exc_src_type'(3'b100 >> i);
            cyc(1);
            exc_req = '0;
            chk(proc_state === ST_EXC, "exception entry");
            wait_exec();
        end
        reset_from(0, 0);
        reset_from(1, 1);
        reset_from(2, 1);
        finish_test();
    end
endmodule
